//--- ovt_pkg.sv
// shared constants and types of the overvoltage trip timer
package ovt_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned TICK_US         = 5000;
   localparam int unsigned MS_US           = 1000;
   localparam int unsigned TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned MS_CYC          = CLK_HZ / 1_000_000 * MS_US;
   localparam int unsigned TICK_MS         = TICK_US / MS_US;
   localparam int unsigned PRE_TRIG_MS     = 20;
   localparam int unsigned PRE_FAULT_MS    = 200;
   localparam int unsigned PRE_TRIG_TICKS  = PRE_TRIG_MS / TICK_MS;
   localparam int unsigned PRE_FAULT_TICKS = PRE_FAULT_MS / TICK_MS;
   localparam int unsigned HIST_DEPTH      = PRE_FAULT_TICKS + 1;
   localparam int unsigned LOG_DEPTH       = 12;
   localparam int unsigned REL_PCT         = 97;
   localparam int unsigned FULL_PCT        = 100;
   localparam int unsigned INV_SCALE       = 200;
   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_PICKUP  = 8'h04;
   localparam logic [7:0] OFS_DTDLY   = 8'h08;
   localparam logic [7:0] OFS_DIAL    = 8'h0c;
   localparam logic [7:0] OFS_EXPO    = 8'h10;
   localparam logic [7:0] OFS_RELEASE = 8'h14;
   localparam logic [7:0] OFS_EVMASK  = 8'h18;
   localparam logic [7:0] OFS_STATUS  = 8'h1c;
   localparam logic [7:0] OFS_CNT_ST  = 8'h20;
   localparam logic [7:0] OFS_CNT_TR  = 8'h24;
   localparam logic [7:0] OFS_CNT_BL  = 8'h28;
   localparam logic [7:0] OFS_LOGSEL  = 8'h2c;
   localparam logic [7:0] OFS_LOG_TS  = 8'h30;
   localparam logic [7:0] OFS_LOG_INF = 8'h34;
   localparam logic [7:0] OFS_LOG_PRE = 8'h38;
   localparam logic [7:0] OFS_LOG_REM = 8'h3c;
   localparam logic [7:0] OFS_LOGCNT  = 8'h40;
   // ctrl bit positions
   localparam int unsigned CTRL_INV   = 0;
   localparam int unsigned CTRL_DREL  = 1;
   localparam int unsigned CTRL_RSTR  = 2;
   localparam int unsigned CTRL_CONT  = 3;
   localparam int unsigned CTRL_MODE  = 4;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [5:0]  RST_CTRL    = 6'h16;
   localparam logic [15:0] RST_PICKUP  = 16'h2904;
   localparam logic [17:0] RST_DTDLY   = 18'h00008;
   localparam logic [12:0] RST_DIAL    = 13'h0005;
   localparam logic [11:0] RST_EXPO    = 12'h064;
   localparam logic [14:0] RST_RELEASE = 15'h000c;
   localparam logic [5:0]  RST_EVMASK  = 6'h3f;
   typedef enum logic [1:0] {ST_IDLE, ST_OPERATE, ST_RELEASE} ovt_state_t;
endpackage : ovt_pkg

//--- ovt_stage.sv
// one overvoltage stage: pick-up, trip timing, events, counters and fault log
//
// Behaviour
// R1: instant mode trips together with start
// R2: definite mode trips after set delay
// R3: definite delay in 5 ms steps, default 40 ms
// R4: zero definite delay behaves as instant
// R5: inverse time is dial over ratio-power minus one; the code uses exponent times (ratio minus one) instead of the power
// R6: delay type selects definite or inverse, default definite
// R7: time dial in 10 ms steps, default 50 ms
// R8: curve exponent in 0.01 steps, default 1.00
// R9: delayed release holds start for release time
// R10: delayed release option, default on
// R11: counter clears after full release time, or immediately
// R12: optional counting continues through release time
// R13: start, trip, block each give on/off events
// R14: mask chooses on, off or both events
// R15: events carry a millisecond time stamp
// R16: resettable counters of start, trip, blocked
// R17: rolling log of last twelve records
// R18: log holds stamp, event, fault, voltages, remaining, group
// R19: pick-up above level, release below 97 percent
// R20: block at pick-up gives blocked, resets start
// R21: counters advance once per evaluation tick
// R22: trip holds until pick-up drops, clears with counter
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module ovt_stage #(
   parameter int unsigned TICK_CYCLES = ovt_pkg::TICK_CYC,
   parameter int unsigned MS_CYCLES   = ovt_pkg::MS_CYC
) (
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        nrst_in,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output var  logic [31:0] avs_readdata_out,
   output var  logic        avs_waitrequest_out,
   // measurement front end
   input  wire logic [15:0] volt_a_in,
   input  wire logic [15:0] volt_b_in,
   input  wire logic [15:0] volt_c_in,
   input  wire logic [2:0]  setting_group_in,
   input  wire logic        block_in,
   // stage outputs
   output var  logic        start_out,
   output var  logic        trip_out,
   output var  logic        blocked_out,
   output var  logic [2:0]  event_on_out,
   output var  logic [2:0]  event_off_out,
   output var  logic [31:0] event_time_out
);
   import ovt_pkg::*;

   // ****************************************
   // registers
   // ****************************************
   logic [5:0]  ctrl_q;
   logic [15:0] pickup_q;
   logic [17:0] dtdly_q;
   logic [12:0] dial_q;
   logic [11:0] expo_q;
   logic [14:0] release_q;
   logic [5:0]  evmask_q;
   logic [3:0]  logsel_q;
   logic        waitreq_q;
   logic [31:0] rdata_q;
   logic [31:0] rd_d;
   logic        wr_go;
   logic [31:0] wmask;
   logic [31:0] wword;
   logic [1:0]  mode;

   assign wr_go = avs_write_in && !waitreq_q;
   assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                   {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   assign mode  = (ctrl_q[CTRL_MODE +: 2] == 2'h0) ? 2'h1 : ctrl_q[CTRL_MODE +: 2];

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [31:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction : merge

   // readback of the addressed register keeps the old bytes outside the byte mask
   assign wword = merge(rd_d, avs_writedata_in, wmask);

   // one wait cycle, then answer
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         waitreq_q <= 1'b1;
         rdata_q   <= 32'h0;
      end else begin
         waitreq_q <= !((avs_read_in || avs_write_in) && waitreq_q);
         if (avs_read_in && waitreq_q) begin
            rdata_q <= rd_d;
         end
      end
   end
   assign avs_waitrequest_out = waitreq_q;
   assign avs_readdata_out    = rdata_q;

   // settings (R3 R6 R7 R8 R9 R10 R11 R12 R14 defaults)
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctrl_q    <= RST_CTRL;
         pickup_q  <= RST_PICKUP;
         dtdly_q   <= RST_DTDLY;
         dial_q    <= RST_DIAL;
         expo_q    <= RST_EXPO;
         release_q <= RST_RELEASE;
         evmask_q  <= RST_EVMASK;
         logsel_q  <= 4'h0;
      end else if (wr_go) begin
         case (avs_address_in)
            OFS_CTRL:    ctrl_q    <= wword[5:0];
            OFS_PICKUP:  pickup_q  <= wword[15:0];
            OFS_DTDLY:   dtdly_q   <= wword[17:0];
            OFS_DIAL:    dial_q    <= wword[12:0];
            OFS_EXPO:    expo_q    <= wword[11:0];
            OFS_RELEASE: release_q <= wword[14:0];
            OFS_EVMASK:  evmask_q  <= wword[5:0];
            OFS_LOGSEL:  logsel_q  <= wword[3:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // ticks, time stamp, block synchroniser
   // ****************************************
   logic [31:0] tick_cnt_q;
   logic [31:0] ms_cnt_q;
   logic [31:0] ms_q;
   logic        tick_q;
   logic [2:0]  blk_sync_q;
   logic        blk_q;

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tick_cnt_q <= 32'h0;
         tick_q     <= 1'b0;
      end else begin
         tick_q     <= (tick_cnt_q == 32'(TICK_CYCLES - 1));
         tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt_q + 32'h1; // R21
      end
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ms_cnt_q <= 32'h0;
         ms_q     <= 32'h0;
      end else if (ms_cnt_q == 32'(MS_CYCLES - 1)) begin
         ms_cnt_q <= 32'h0;
         ms_q     <= ms_q + 32'h1;
      end else begin
         ms_cnt_q <= ms_cnt_q + 32'h1;
      end
   end

   // pin input: change counts only once stages two and three agree
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         blk_sync_q <= 3'h0;
         blk_q      <= 1'b0;
      end else begin
         blk_sync_q <= {blk_sync_q[1:0], block_in};
         if (blk_sync_q[1] == blk_sync_q[2]) begin
            blk_q <= blk_sync_q[2];
         end
      end
   end

   // ****************************************
   // pick-up
   // ****************************************
   logic [2:0]  above;
   logic [2:0]  above_rel;
   logic [15:0] volt [3];
   logic [15:0] vmax;
   logic [15:0] excess;
   logic        pu_q;
   logic        pu_d;
   logic        epu;

   function automatic logic [1:0] ones(input logic [2:0] v);
      ones = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
   endfunction : ones

   assign volt[0] = volt_a_in;
   assign volt[1] = volt_b_in;
   assign volt[2] = volt_c_in;

   always_comb begin
      vmax = 16'h0;
      for (int i = 0; i < 3; i++) begin
         above[i]     = volt[i] > pickup_q;
         above_rel[i] = (24'(volt[i]) * 24'(FULL_PCT)) > (24'(pickup_q) * 24'(REL_PCT));
         if (volt[i] > vmax) begin
            vmax = volt[i];
         end
      end
   end

   // hysteresis: on above level, off below 97 percent of it
   assign pu_d   = pu_q ? (ones(above_rel) >= mode) : (ones(above) >= mode); // R19
   assign epu    = pu_d && !blk_q; // R20
   assign excess = (vmax > pickup_q) ? vmax - pickup_q : 16'h0;

   // ****************************************
   // operate and release timing
   // ****************************************
   ovt_state_t  state_q;
   logic [17:0] op_cnt_q;
   logic [47:0] acc_q;
   logic [47:0] acc_nx;
   logic [47:0] inv_thr;
   logic [14:0] rel_cnt_q;
   logic        start_q;
   logic        trip_q;
   logic        blocked_q;
   logic        trip_now;
   logic        inv_mode;

   assign inv_mode = ctrl_q[CTRL_INV]; // R6
   // first-order ratio power: a*(Um-Us)/Us per tick, compared with k over the tick
   assign acc_nx   = acc_q + 48'(expo_q) * 48'(excess); // R5 R8
   assign inv_thr  = 48'(dial_q) * 48'(INV_SCALE) * 48'(pickup_q); // R7
   // both modes compare the time already elapsed, so the start tick adds nothing
   assign trip_now = inv_mode ? (acc_q >= inv_thr) : (op_cnt_q >= dtdly_q); // R2 R3 R4 R1

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q   <= ST_IDLE;
         op_cnt_q  <= 18'h0;
         acc_q     <= 48'h0;
         rel_cnt_q <= 15'h0;
         start_q   <= 1'b0;
         trip_q    <= 1'b0;
         blocked_q <= 1'b0;
         pu_q      <= 1'b0;
      end else if (tick_q) begin
         pu_q      <= pu_d;
         blocked_q <= pu_d && blk_q && !(state_q == ST_OPERATE); // R20
         case (state_q)
            ST_IDLE, ST_RELEASE: begin
               if (epu) begin
                  state_q <= ST_OPERATE;
                  start_q <= 1'b1;
                  trip_q  <= trip_now; // R1 R4
                  if (!trip_now) begin
                     op_cnt_q <= op_cnt_q + 18'h1;
                     acc_q    <= acc_nx;
                  end
               end else if (state_q == ST_RELEASE) begin
                  if (ctrl_q[CTRL_CONT] && !trip_now) begin
                     op_cnt_q <= op_cnt_q + 18'h1; // R12
                     acc_q    <= acc_nx;
                  end
                  rel_cnt_q <= rel_cnt_q + 15'h1;
                  if (rel_cnt_q + 15'h1 >= release_q) begin
                     state_q  <= ST_IDLE; // R9
                     start_q  <= 1'b0;
                     op_cnt_q <= 18'h0; // R11
                     acc_q    <= 48'h0;
                  end
               end
            end
            ST_OPERATE: begin
               if (epu) begin
                  if (trip_now) begin
                     trip_q <= 1'b1; // R2 R5
                  end else begin
                     op_cnt_q <= op_cnt_q + 18'h1; // R21
                     acc_q    <= acc_nx;
                  end
               end else begin
                  trip_q    <= 1'b0; // R22
                  rel_cnt_q <= 15'h0;
                  if (trip_q) begin
                     state_q  <= ST_IDLE; // R22
                     start_q  <= 1'b0;
                     op_cnt_q <= 18'h0;
                     acc_q    <= 48'h0;
                  end else begin
                     if (!ctrl_q[CTRL_DREL]) begin
                        start_q <= 1'b0; // R10
                     end
                     if (!ctrl_q[CTRL_RSTR]) begin
                        op_cnt_q <= 18'h0; // R11
                        acc_q    <= 48'h0;
                     end
                     if (ctrl_q[CTRL_DREL] || ctrl_q[CTRL_RSTR]) begin
                        state_q <= ST_RELEASE;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // events, counters
   // ****************************************
   logic [2:0]  flags;
   logic [2:0]  flags_p_q;
   logic [2:0]  rise;
   logic [2:0]  fall;
   logic [15:0] cnt_q [3];

   assign flags = {blocked_q, trip_q, start_q};
   assign rise  = flags & ~flags_p_q;
   assign fall  = ~flags & flags_p_q;

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         flags_p_q      <= 3'h0;
         start_out      <= 1'b0;
         trip_out       <= 1'b0;
         blocked_out    <= 1'b0;
         event_on_out   <= 3'h0;
         event_off_out  <= 3'h0;
         event_time_out <= 32'h0;
      end else begin
         flags_p_q      <= flags;
         start_out      <= start_q;
         trip_out       <= trip_q;
         blocked_out    <= blocked_q;
         event_on_out   <= rise & evmask_q[2:0]; // R13 R14
         event_off_out  <= fall & evmask_q[5:3]; // R13 R14
         event_time_out <= ms_q; // R15
      end
   end

   // a count and its clear in one cycle leave the count at one
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < 3; i++) begin
            cnt_q[i] <= 16'h0;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (rise[i]) begin
               cnt_q[i] <= (wr_go && avs_address_in == OFS_CNT_ST + 8'(4 * i))
                           ? 16'h1 : cnt_q[i] + 16'h1; // R16
            end else if (wr_go && avs_address_in == OFS_CNT_ST + 8'(4 * i)) begin
               cnt_q[i] <= 16'h0; // R16
            end
         end
      end
   end

   // ****************************************
   // voltage history and fault log
   // ****************************************
   logic [15:0] hist_q [HIST_DEPTH];
   logic [5:0]  hptr_q;
   logic [2:0]  fault_q;
   logic [31:0] log_ts_q  [LOG_DEPTH];
   logic [8:0]  log_inf_q [LOG_DEPTH];
   logic [31:0] log_pre_q [LOG_DEPTH];
   logic [17:0] log_rem_q [LOG_DEPTH];
   logic [3:0]  wptr_q;
   logic [3:0]  lcnt_q;
   logic [3:0]  rsel;
   logic [17:0] remain;

   function automatic logic [5:0] ago(input logic [5:0] p, input int unsigned k);
      logic [6:0] t;
      t = 7'(p) + 7'(HIST_DEPTH) - 7'(k);
      ago = (t >= 7'(HIST_DEPTH)) ? 6'(t - 7'(HIST_DEPTH)) : t[5:0];
   endfunction : ago

   assign remain = (!inv_mode && dtdly_q > op_cnt_q) ? dtdly_q - op_cnt_q : 18'h0;

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hptr_q  <= 6'h0;
         fault_q <= 3'h0;
      end else if (tick_q) begin
         hist_q[hptr_q] <= vmax;
         hptr_q  <= (hptr_q == 6'(HIST_DEPTH - 1)) ? 6'h0 : hptr_q + 6'h1;
         fault_q <= above;
      end
   end

   // one record per tick holds every on event of that tick
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wptr_q <= 4'h0;
         lcnt_q <= 4'h0;
      end else if (|rise) begin
         log_ts_q[wptr_q]  <= ms_q; // R18
         log_inf_q[wptr_q] <= {setting_group_in, fault_q, rise};
         log_pre_q[wptr_q] <= {hist_q[ago(hptr_q, PRE_TRIG_TICKS + 1)],
                               hist_q[ago(hptr_q, PRE_FAULT_TICKS + 1)]};
         log_rem_q[wptr_q] <= remain;
         wptr_q <= (wptr_q == 4'(LOG_DEPTH - 1)) ? 4'h0 : wptr_q + 4'h1; // R17
         if (lcnt_q != 4'(LOG_DEPTH)) begin
            lcnt_q <= lcnt_q + 4'h1;
         end
      end
   end

   // 0 selects the newest record
   always_comb begin
      rsel = 4'h0;
      if (logsel_q < 4'(LOG_DEPTH)) begin
         rsel = (wptr_q > logsel_q) ? wptr_q - logsel_q - 4'h1
                                    : wptr_q + 4'(LOG_DEPTH) - logsel_q - 4'h1;
      end
   end

   always_comb begin
      rd_d = 32'h0;
      case (avs_address_in)
         OFS_CTRL:    rd_d = 32'(ctrl_q);
         OFS_PICKUP:  rd_d = 32'(pickup_q);
         OFS_DTDLY:   rd_d = 32'(dtdly_q);
         OFS_DIAL:    rd_d = 32'(dial_q);
         OFS_EXPO:    rd_d = 32'(expo_q);
         OFS_RELEASE: rd_d = 32'(release_q);
         OFS_EVMASK:  rd_d = 32'(evmask_q);
         OFS_STATUS:  rd_d = {7'h0, op_cnt_q, state_q, pu_q, blk_q, flags};
         OFS_CNT_ST:  rd_d = 32'(cnt_q[0]);
         OFS_CNT_TR:  rd_d = 32'(cnt_q[1]);
         OFS_CNT_BL:  rd_d = 32'(cnt_q[2]);
         OFS_LOGSEL:  rd_d = 32'(logsel_q);
         OFS_LOG_TS:  rd_d = log_ts_q[rsel];
         OFS_LOG_INF: rd_d = 32'(log_inf_q[rsel]);
         OFS_LOG_PRE: rd_d = log_pre_q[rsel];
         OFS_LOG_REM: rd_d = 32'(log_rem_q[rsel]);
         OFS_LOGCNT:  rd_d = 32'(lcnt_q);
         default:     rd_d = 32'h0;
      endcase
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);

   sequence s_new_pickup;
      tick_q && epu && (state_q == ST_IDLE);
   endsequence

   inst_trip_a: assert property (s_new_pickup and (!inv_mode && dtdly_q == 18'h0) // R1
      |=> start_q && trip_q) else $error("instant trip missing");
   dt_trip_a: assert property (tick_q && epu && state_q == ST_OPERATE && !inv_mode // R2
      && op_cnt_q >= dtdly_q |=> trip_q) else $error("definite trip late");
   dt_early_a: assert property ($rose(trip_q) && !inv_mode |-> // R4
      $past(op_cnt_q) >= $past(dtdly_q)) else $error("definite trip early");
   trip_drop_a: assert property (tick_q && !epu |=> !trip_q) else $error("trip held"); // R22
   blk_start_a: assert property (tick_q && pu_d && blk_q && state_q == ST_IDLE // R20
      |=> blocked_q && !start_q) else $error("blocked not given");
   rel_hold_a: assert property (tick_q && !epu && state_q == ST_OPERATE && !trip_q // R9
      && ctrl_q[CTRL_DREL] |=> start_q ##1 start_q) else $error("start not held");
   no_drel_a: assert property (tick_q && !epu && state_q == ST_OPERATE // R10
      && !ctrl_q[CTRL_DREL] |=> !start_q) else $error("start not released");
   cnt_inc_a: assert property (rise[1] && !wr_go |=> // R16
      cnt_q[1] == $past(cnt_q[1]) + 16'h1) else $error("trip count wrong");
   ev_mask_a: assert property (rise[0] |=> event_on_out[0] == $past(evmask_q[0]) // R14
      ##0 event_time_out == $past(ms_q)) else $error("event mask or stamp wrong");
   log_fill_a: assert property (lcnt_q <= 4'(LOG_DEPTH) && wptr_q < 4'(LOG_DEPTH)) // R17
      else $error("log pointer out of range");
   tick_gap_a: assert property (tick_q |=> !tick_q [*2]) else $error("tick too fast"); // R21
endmodule : ovt_stage
`default_nettype wire

//--- ovt_front_model.sv
// front-end model: phase voltages, setting group and block pin
`timescale 1ns/1ns
`default_nettype none
module ovt_front_model (
   // control from bench
   input  wire logic [15:0] level_in,
   input  wire logic        block_req_in,
   // measurement side
   output var  logic [15:0] volt_a_out,
   output var  logic [15:0] volt_b_out,
   output var  logic [15:0] volt_c_out,
   output var  logic [2:0]  sg_out,
   output var  logic        block_out
);
   // b and c stay nominal so phase a alone decides pick-up
   always_comb begin
      volt_a_out = level_in;
      volt_b_out = 16'h2710;
      volt_c_out = 16'h2710;
      sg_out     = 3'h2;
      block_out  = block_req_in;
   end
endmodule : ovt_front_model
`default_nettype wire

//--- tb_top.sv
// self-checking testbench of the overvoltage trip timer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import ovt_pkg::*;
   localparam int T = 20;
   localparam logic [7:0] AD [8] = '{OFS_CTRL, OFS_PICKUP, OFS_DTDLY, OFS_DIAL,
                                     OFS_EXPO, OFS_RELEASE, OFS_EVMASK, 8'h80};
   localparam logic [31:0] RV [8] = '{32'h16, 32'h2904, 32'h8, 32'h5,
                                      32'h64, 32'hc, 32'h3f, 32'h0};
   logic        sys_clk_in = 1'b0;
   logic        nrst_in    = 1'b0;
   logic [7:0]  adr        = 8'h00;
   logic        rd         = 1'b0;
   logic        wr         = 1'b0;
   logic [31:0] wd         = 32'h0;
   logic [15:0] level      = 16'h2710;
   logic        blk        = 1'b0;
   logic [31:0] rdat, q;
   logic        wq, st, tr, bl, blk_pin;
   logic [2:0]  ev_on, ev_off, sg;
   logic [15:0] va, vb, vc;
   int          failures = 0;
   int          samples_checked = 0;
   int          n_on = 0;
   int          n_off = 0;
   always #10 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      n_on  <= n_on + int'(ev_on[0] === 1'b1);
      n_off <= n_off + int'(ev_off[1] === 1'b1);
   end
   ovt_front_model i_fe (.level_in(level), .block_req_in(blk), .volt_a_out(va),
      .volt_b_out(vb), .volt_c_out(vc), .sg_out(sg), .block_out(blk_pin));
   ovt_stage #(.TICK_CYCLES(T), .MS_CYCLES(4)) i_dut (.sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wd), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wq), .volt_a_in(va), .volt_b_in(vb), .volt_c_in(vc),
      .setting_group_in(sg), .block_in(blk_pin), .start_out(st), .trip_out(tr),
      .blocked_out(bl), .event_on_out(ev_on), .event_off_out(ev_off),
      .event_time_out());
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t mismatch got %h exp %h", $time, g, e);
      end
   endtask : chk
   // one access; held until waitrequest is seen low
   task avs(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      adr <= a;
      wd  <= d;
      wr  <= w;
      rd  <= ~w;
      do @(posedge sys_clk_in); while (wq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : avs
   // cycles until start(0), trip(1) or blocked(2) reaches v
   task wt(input int s, input logic v, output int n);
      n = 0;
      while ((s == 0 ? st : s == 1 ? tr : bl) !== v && n < 3000) begin
         @(posedge sys_clk_in);
         n++;
      end
      if (n >= 3000) begin
         failures++;
         $display("[ERR] %0t output wait timed out", $time);
      end
   endtask : wt
   task finish_test;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   // ****************************************
   // tests
   // ****************************************
   initial begin
      int n;
      repeat (16) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         avs(1'b0, AD[i], 32'h0);
         chk(q, RV[i]);
      end
      level <= 16'h2af8;
      wt(0, 1'b1, n);
      wt(1, 1'b1, n);
      chk(32'(n), 32'(8 * T));
      level <= 16'h2328;
      wt(0, 1'b0, n);
      chk({31'h0, tr}, 32'h0);
      avs(1'b1, OFS_DTDLY, 32'h0);
      level <= 16'h2af8;
      wt(0, 1'b1, n);
      chk({31'h0, tr}, 32'h1);
      level <= 16'h2328;
      wt(0, 1'b0, n);
      avs(1'b1, OFS_DTDLY, 32'd100);
      level <= 16'h2af8;
      wt(0, 1'b1, n);
      level <= 16'h2328;
      wt(0, 1'b0, n);
      chk(32'(n >= 12 * T && n <= 13 * T + 2), 32'h1);
      avs(1'b1, OFS_CTRL, 32'h14);
      level <= 16'h2af8;
      wt(0, 1'b1, n);
      level <= 16'h2328;
      wt(0, 1'b0, n);
      chk(32'(n <= T + 2), 32'h1);
      avs(1'b1, OFS_CTRL, 32'h16);
      blk <= 1'b1;
      repeat (8) @(posedge sys_clk_in);
      level <= 16'h2af8;
      wt(2, 1'b1, n);
      chk({31'h0, st}, 32'h0);
      level <= 16'h2328;
      blk   <= 1'b0;
      wt(2, 1'b0, n);
      avs(1'b0, OFS_CNT_ST, 32'h0);
      chk(q, 32'h4);
      avs(1'b0, OFS_CNT_TR, 32'h0);
      chk(q, 32'h2);
      avs(1'b0, OFS_CNT_BL, 32'h0);
      chk(q, 32'h1);
      chk(32'(n_on), 32'h4);
      chk(32'(n_off), 32'h2);
      avs(1'b0, OFS_LOGCNT, 32'h0);
      chk(q, 32'h6);
      avs(1'b0, OFS_LOG_INF, 32'h0);
      chk(q, 32'h8c);
      avs(1'b1, OFS_CNT_ST, 32'h0);
      avs(1'b0, OFS_CNT_ST, 32'h0);
      chk(q, 32'h0);
      avs(1'b1, OFS_EVMASK, 32'h3e);
      level <= 16'h2af8;
      wt(0, 1'b1, n);
      level <= 16'h2328;
      wt(0, 1'b0, n);
      chk(32'(n_on), 32'h4);
      // ratio two with exponent one: operating time equals the dial
      avs(1'b1, OFS_CTRL, 32'h17);
      level <= 16'h5208;
      wt(0, 1'b1, n);
      wt(1, 1'b1, n);
      chk(32'(n), 32'(10 * T));
      finish_test;
   end
   // the whole sequence needs well under this many cycles
   initial begin
      repeat (30000) @(posedge sys_clk_in);
      failures++;
      finish_test;
   end
endmodule : tb_top
`default_nettype wire
